// >>> verilog/cacr_config_bank.v
/*
 * AXI4-Lite register bank for the converter analog configuration.
 * Assumes a single core clock, active-low async reset and a capture
 * block that supplies the sync edge position with a one-cycle strobe.
 */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cacr_regs.vh"

module cacr_config_bank #(
    parameter LANES = 16
) (
    input  wire                 core_clk,
    input  wire                 rstn,
    input  wire [9:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [9:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire [23:0]          syncEdgeCapture,
    input  wire                 syncEdgeCaptureValid,
    output wire                 clockFeedbackGainHigh,
    output wire                 supplyNoiseSuppressEn,
    output wire [1:0]           samplingClockDelay,
    output wire [3:0]           syncDelaySelect,
    output wire                 syncWindowZoom,
    output wire [15:0]          fullscaleCodeA,
    output wire [15:0]          fullscaleCodeB,
    output wire                 referenceBypass,
    output wire                 stampReceiverEn,
    output wire                 stampPeclModeEn,
    output wire [3*LANES-1:0]   laneEmphasisLevel,
    output wire                 laneEmphasisBoost
);

    reg  [7:0]  clkCtrl0;
    reg  [7:0]  clkCtrl2;
    reg  [23:0] syncEdgePosition;
    reg  [15:0] rangeA;
    reg  [15:0] rangeB;
    reg  [7:0]  refSel;
    reg  [7:0]  stampCtrl;
    reg  [7:0]  emphasis;
    reg         awHeld;
    reg         wHeld;
    reg  [9:0]  awAddrHeld;
    reg  [31:0] wDataHeld;
    reg  [3:0]  wStrbHeld;

    // Byte lane merge for one register word
    function [31:0] mergeBytes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  strb;
        integer      i;
        begin
            mergeBytes = oldVal;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i])
                    mergeBytes[8*i +: 8] = newVal[8*i +: 8];
            end
        end
    endfunction

    // Printed offsets are not all word aligned: byte address = index*4
    function mapped;
        input [9:0] addr;
        begin
            case (addr[9:2])
                `CACR_IDX_CLK_CTRL0,
                `CACR_IDX_CLOCK_PATH_CONTROL_TWO,
                `CACR_IDX_SYNC_POS,
                `CACR_IDX_RANGE_A,
                `CACR_IDX_RANGE_B,
                `CACR_IDX_REF_SEL,
                `CACR_IDX_STAMP_CTRL,
                `CACR_IDX_EMPHASIS: mapped = 1'b1;
                default:            mapped = 1'b0;
            endcase
        end
    endfunction

    // Read mux; unmapped words and reserved bits read zero
    function [31:0] readWord;
        input [9:0] addr;
        begin
            case (addr[9:2])
                `CACR_IDX_CLK_CTRL0: begin
                    readWord = {24'h00_0000, clkCtrl0};
                end
                `CACR_IDX_CLOCK_PATH_CONTROL_TWO: begin
                    readWord = {24'h00_0000, clkCtrl2};
                end
                `CACR_IDX_SYNC_POS: begin
                    readWord = {8'h00, syncEdgePosition};
                end
                `CACR_IDX_RANGE_A: begin
                    readWord = {16'h0000, rangeA};
                end
                `CACR_IDX_RANGE_B: begin
                    readWord = {16'h0000, rangeB};
                end
                `CACR_IDX_REF_SEL: begin
                    readWord = {24'h00_0000, refSel};
                end
                `CACR_IDX_STAMP_CTRL: begin
                    readWord = {24'h00_0000, stampCtrl};
                end
                `CACR_IDX_EMPHASIS: begin
                    readWord = {24'h00_0000, emphasis};
                end
                default: begin
                    readWord = 32'h0000_0000;
                end
            endcase
        end
    endfunction

    // Write path: address and data taken in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;

    wire        awTake   = s_axi_awvalid && s_axi_awready;
    wire        wTake    = s_axi_wvalid && s_axi_wready;
    wire        haveAw   = awHeld || awTake;
    wire        haveW    = wHeld || wTake;
    wire        doWrite  = haveAw && haveW && !s_axi_bvalid;
    wire [9:0]  wrAddr   = awHeld ? awAddrHeld : s_axi_awaddr;
    wire [31:0] wrData   = wHeld ? wDataHeld : s_axi_wdata;
    wire [3:0]  wrStrb   = wHeld ? wStrbHeld : s_axi_wstrb;

    // Address hold: kept until the matching data arrives
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld     <= 1'b0;
            awAddrHeld <= 10'h000;
        end else if (doWrite) begin
            awHeld     <= 1'b0;
        end else if (awTake) begin
            awHeld     <= 1'b1;
            awAddrHeld <= s_axi_awaddr;
        end
    end

    // Data hold: either channel may arrive first
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wHeld     <= 1'b0;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
        end else if (doWrite) begin
            wHeld     <= 1'b0;
        end else if (wTake) begin
            wHeld     <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
        end
    end

    // Response stands until the master takes it
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CACR_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wrAddr) ? `CACR_RESP_OKAY
                                           : `CACR_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    wire [31:0] wrMerged     = mergeBytes(32'h0000_0000, wrData, wrStrb);
    wire [31:0] rangeAMerged = mergeBytes({16'h0000, rangeA}, wrData, wrStrb);
    wire [31:0] rangeBMerged = mergeBytes({16'h0000, rangeB}, wrData, wrStrb);

    reg  [7:0]  next_clkCtrl0;
    reg  [7:0]  next_clkCtrl2;
    reg  [15:0] next_rangeA;
    reg  [15:0] next_rangeB;
    reg  [7:0]  next_refSel;
    reg  [7:0]  next_stampCtrl;
    reg  [7:0]  next_emphasis;

    // Reserved bits are masked so they stay zero
    always @* begin
        next_clkCtrl0  = clkCtrl0;
        next_clkCtrl2  = clkCtrl2;
        next_rangeA    = rangeA;
        next_rangeB    = rangeB;
        next_refSel    = refSel;
        next_stampCtrl = stampCtrl;
        next_emphasis  = emphasis;
        if (doWrite) begin
            case (wrAddr[9:2])
                `CACR_IDX_CLK_CTRL0: begin
                    if (wrStrb[0]) begin
                        next_clkCtrl0 = wrMerged[7:0] & `CACR_MASK_CLK0;
                    end
                end
                `CACR_IDX_CLOCK_PATH_CONTROL_TWO: begin
                    if (wrStrb[0]) begin
                        next_clkCtrl2 = wrMerged[7:0] & `CACR_MASK_CLK2;
                    end
                end
                `CACR_IDX_RANGE_A: begin
                    next_rangeA = rangeAMerged[15:0];
                end
                `CACR_IDX_RANGE_B: begin
                    next_rangeB = rangeBMerged[15:0];
                end
                `CACR_IDX_REF_SEL: begin
                    if (wrStrb[0]) begin
                        next_refSel = wrMerged[7:0] & `CACR_MASK_REF;
                    end
                end
                `CACR_IDX_STAMP_CTRL: begin
                    if (wrStrb[0]) begin
                        next_stampCtrl = wrMerged[7:0] & `CACR_MASK_STAMP;
                    end
                end
                `CACR_IDX_EMPHASIS: begin
                    if (wrStrb[0]) begin
                        next_emphasis = wrMerged[7:0] & `CACR_MASK_EMPH;
                    end
                end
                // Position word and unmapped words ignore writes
                default: begin
                    next_clkCtrl0 = clkCtrl0;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clkCtrl0  <= `CACR_RST_ZERO8;
            clkCtrl2  <= {3'h0, `CACR_RST_GAIN, 2'h0, `CACR_RST_DELAY};
            rangeA    <= `CACR_RST_RANGE;
            rangeB    <= `CACR_RST_RANGE;
            refSel    <= `CACR_RST_ZERO8;
            stampCtrl <= `CACR_RST_ZERO8;
            emphasis  <= `CACR_RST_ZERO8;
        end else begin
            clkCtrl0  <= next_clkCtrl0;
            clkCtrl2  <= next_clkCtrl2;
            rangeA    <= next_rangeA;
            rangeB    <= next_rangeB;
            refSel    <= next_refSel;
            stampCtrl <= next_stampCtrl;
            emphasis  <= next_emphasis;
        end
    end

    // Capture only; software has no write path here
    always @(posedge core_clk) begin
        if (syncEdgeCaptureValid)
            syncEdgePosition <= syncEdgeCapture;
    end

    // Read path: one read at a time, answer one cycle after address
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CACR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `CACR_RESP_OKAY
                                                 : `CACR_RESP_SLVERR;
            s_axi_rdata  <= readWord(s_axi_araddr);
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign clockFeedbackGainHigh = clkCtrl2[`CACR_CLK2_GAIN_BIT];
    assign supplyNoiseSuppressEn = clkCtrl2[`CACR_CLK2_NOISE_BIT];
    assign samplingClockDelay    = clkCtrl2[`CACR_CLK2_DELAY_LSB +: 2];
    assign syncDelaySelect       = clkCtrl0[`CACR_CLK0_SEL_LSB +: 4];
    assign syncWindowZoom        = clkCtrl0[`CACR_CLK0_ZOOM_BIT];
    assign fullscaleCodeA        = rangeA;
    assign fullscaleCodeB        = rangeB;
    assign referenceBypass       = refSel[`CACR_REF_BYPASS_BIT];
    assign stampReceiverEn       = stampCtrl[`CACR_STAMP_RECV_BIT];
    assign stampPeclModeEn       = stampCtrl[`CACR_STAMP_PECL_BIT];
    // One shared level fanned to every lane
    assign laneEmphasisLevel     =
        {LANES{emphasis[`CACR_EMPH_LEVEL_LSB +: 3]}};
    assign laneEmphasisBoost     = emphasis[`CACR_EMPH_BOOST_BIT];

endmodule // cacr_config_bank

// >>> verilog/cacr_regs.vh
/*
 * Register map constants for the converter analog configuration bank.
 * Assumes inclusion by the bank module; definitions only.
 */
`ifndef CACR_REGS_VH
`define CACR_REGS_VH

`define CACR_IDX_CLK_CTRL0      8'h29
`define CACR_IDX_CLOCK_PATH_CONTROL_TWO      8'h2B
`define CACR_IDX_SYNC_POS       8'h2C
`define CACR_IDX_RANGE_A        8'h30
`define CACR_IDX_RANGE_B        8'h32
`define CACR_IDX_REF_SEL        8'h38
`define CACR_IDX_STAMP_CTRL     8'h3B
`define CACR_IDX_EMPHASIS       8'h48

`define CACR_CLK2_DELAY_LSB     0
`define CACR_CLK2_NOISE_BIT     2
`define CACR_CLK2_GAIN_BIT      4
`define CACR_CLK0_ZOOM_BIT      4
`define CACR_CLK0_SEL_LSB       0
`define CACR_REF_BYPASS_BIT     0
`define CACR_STAMP_RECV_BIT     0
`define CACR_STAMP_PECL_BIT     1
`define CACR_EMPH_LEVEL_LSB     0
`define CACR_EMPH_BOOST_BIT     3

`define CACR_RST_DELAY          2'h1
`define CACR_RST_GAIN           1'h1
`define CACR_RST_RANGE          16'hA000
`define CACR_RST_ZERO8          8'h00

`define CACR_MASK_CLK0          8'h1F
`define CACR_MASK_CLK2          8'h17
`define CACR_MASK_REF           8'h01
`define CACR_MASK_STAMP         8'h03
`define CACR_MASK_EMPH          8'h0F

`define CACR_RESP_OKAY          2'h0
`define CACR_RESP_SLVERR        2'h2

`endif

// >>> verification/cacr_config_bank_props.sv
/*
 * Port checker for the analog configuration register bank.
 * Assumes it is bound into the bank and sees only its ports.
 */
`timescale 1ns/1ps
module cacr_config_bank_props #(
    parameter LANES = 16
) (
    input wire          core_clk, rstn, s_axi_awvalid, s_axi_awready,
    input wire          s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire          s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire [9:0]    s_axi_awaddr, s_axi_araddr,
    input wire [31:0]   s_axi_wdata, s_axi_rdata,
    input wire [3:0]    s_axi_wstrb, syncDelaySelect,
    input wire [23:0]   syncEdgeCapture,
    input wire          syncEdgeCaptureValid, clockFeedbackGainHigh,
    input wire          supplyNoiseSuppressEn, syncWindowZoom,
    input wire          referenceBypass, stampReceiverEn, stampPeclModeEn,
    input wire          laneEmphasisBoost,
    input wire [1:0]    samplingClockDelay,
    input wire [15:0]   fullscaleCodeA, fullscaleCodeB,
    input wire [3*LANES-1:0] laneEmphasisLevel
);
    reg [9:0]  lastA, lastR;
    reg [31:0] lastW;
    reg [3:0]  lastS;
    reg [23:0] lastCap;
    reg        capSeen;
    always @(posedge core_clk) begin
        if (s_axi_awvalid && s_axi_awready) lastA <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) lastW <= s_axi_wdata;
        if (s_axi_wvalid && s_axi_wready) lastS <= s_axi_wstrb;
        if (s_axi_arvalid && s_axi_arready) lastR <= s_axi_araddr;
        if (syncEdgeCaptureValid) lastCap <= syncEdgeCapture;
    end
    // Position word has no reset, so reads are judged only after a capture
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) capSeen <= 1'b0;
        else if (syncEdgeCaptureValid) capSeen <= 1'b1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_clk2_write: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0ac && lastS[0] |->
        {clockFeedbackGainHigh, supplyNoiseSuppressEn, samplingClockDelay}
        == {lastW[4], lastW[2], lastW[1:0]}) else $error("clk2 mismatch");
    a_clk0_write: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0a4 && lastS[0] |->
        {syncWindowZoom, syncDelaySelect} == lastW[4:0])
        else $error("clk0 mismatch");
    a_range_a: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0c0 && lastS[1:0] == 2'h3 |->
        fullscaleCodeA == lastW[15:0]) else $error("range A mismatch");
    a_range_b: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0c8 && lastS[1:0] == 2'h3 |->
        fullscaleCodeB == lastW[15:0]) else $error("range B mismatch");
    a_ref_write: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0e0 && lastS[0] |->
        referenceBypass == lastW[0]) else $error("bypass mismatch");
    a_stamp_write: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h0ec && lastS[0] |->
        {stampPeclModeEn, stampReceiverEn} == lastW[1:0])
        else $error("stamp mismatch");
    a_emph_write: assert property (
        $rose(s_axi_bvalid) && lastA == 10'h120 && lastS[0] |->
        {laneEmphasisBoost, laneEmphasisLevel[2:0]} == lastW[3:0])
        else $error("emphasis mismatch");
    a_emph_copies: assert property (
        laneEmphasisLevel == {LANES{laneEmphasisLevel[2:0]}})
        else $error("lane copies differ");
    a_pos_read: assert property (
        $rose(s_axi_rvalid) && lastR == 10'h0b0 && capSeen |->
        s_axi_rdata == {8'h00, lastCap}) else $error("position mismatch");
    a_range_hold: assert property (
        !$rose(s_axi_bvalid) |-> $stable({fullscaleCodeA, fullscaleCodeB}))
        else $error("range changed without write");
endmodule // cacr_config_bank_props

bind cacr_config_bank cacr_config_bank_props #(.LANES(LANES)) i_props (
    .core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_rdata,
    .s_axi_wstrb, .syncDelaySelect, .syncEdgeCapture, .syncEdgeCaptureValid,
    .clockFeedbackGainHigh, .supplyNoiseSuppressEn, .syncWindowZoom,
    .referenceBypass, .stampReceiverEn, .stampPeclModeEn, .laneEmphasisBoost,
    .samplingClockDelay, .fullscaleCodeA, .fullscaleCodeB, .laneEmphasisLevel
);

// >>> verification/test_cacr_config_bank.sv
/*
 * Self-checking bench for the analog configuration register bank.
 * Assumes AXI4-Lite answers of unfixed latency and a capture strobe.
 */
`timescale 1ns/1ps
module test_cacr_config_bank;
    logic        core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        capValid, awready, wready, arready, bvalid, rvalid;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [23:0] capture;
    wire  [44:0] cfg;
    wire  [47:0] level;
    int          numErrors = 0, cmpCount = 0, seed = 32'h0000_8d14;
    logic [31:0] mdl [0:6];
    logic [9:0]  adr [0:6] = '{10'h0a4, 10'h0ac, 10'h0c0, 10'h0c8, 10'h0e0,
                               10'h0ec, 10'h120};
    logic [31:0] msk [0:6] = '{32'h0000_001f, 32'h0000_0017, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_0001, 32'h0000_0003, 32'h0000_000f};
    logic [31:0] rst [0:6] = '{32'h0000_0000, 32'h0000_0011, 32'h0000_a000,
        32'h0000_a000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    cacr_config_bank #(.LANES(16)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .syncEdgeCapture(capture), .syncEdgeCaptureValid(capValid),
        .fullscaleCodeA(cfg[15:0]), .fullscaleCodeB(cfg[31:16]),
        .clockFeedbackGainHigh(cfg[32]), .supplyNoiseSuppressEn(cfg[33]),
        .samplingClockDelay(cfg[35:34]), .syncDelaySelect(cfg[39:36]),
        .syncWindowZoom(cfg[40]), .referenceBypass(cfg[41]),
        .stampReceiverEn(cfg[42]), .stampPeclModeEn(cfg[43]),
        .laneEmphasisBoost(cfg[44]), .laneEmphasisLevel(level));

    function automatic logic [44:0] expCfg();
        expCfg = {mdl[6][3], mdl[5][1:0], mdl[4][0], mdl[0][4:0],
                  mdl[1][1:0], mdl[1][2], mdl[1][4], mdl[3][15:0],
                  mdl[2][15:0]};
    endfunction

    task automatic summarize();
        $display("Comparisons %0d, errors %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmpCount++;
        if (g !== e) begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Address and data are released on their own ready, not together
        do begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (bvalid !== 1'b1) begin
            numErrors++;
            summarize();
        end
    endtask

    task automatic rd(input logic [9:0] a);
        int n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        got = rdata;
        r = rresp;
        rready <= 1'b0;
        if (rvalid !== 1'b1) begin
            numErrors++;
            summarize();
        end
    endtask

    task automatic wrChk(input int i, input logic [31:0] d,
                         input logic [3:0] s);
        wr(adr[i], d, s);
        for (int b = 0; b < 4; b++)
            if (s[b]) mdl[i][8*b +: 8] = d[8*b +: 8];
        mdl[i] = mdl[i] & msk[i];
        chk(r, 2'h0);
        rd(adr[i]);
        chk(got, mdl[i]);
        chk(cfg, expCfg());
        chk(level, {16{mdl[6][2:0]}});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, capValid} = 7'h00;
        {awaddr, araddr, wdata, wstrb, capture} = 80'h0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            mdl[i] = rst[i];
            rd(adr[i]);
            chk(got, rst[i]);
        end
        chk(cfg, expCfg());
        wrChk(2, 32'h0000_2000, 4'h3);
        wrChk(3, 32'hffff_ffff, 4'h3);
        wrChk(1, 32'hffff_ffff, 4'hf);
        wrChk(5, 32'h0000_0002, 4'h1);
        for (int k = 0; k < 40; k++)
            wrChk($unsigned($random(seed)) % 7,
                  $random(seed) | 32'h0000_8000, $random(seed));
        wr(10'h0a8, 32'hffff_ffff, 4'hf);
        chk(r, 2'h2);
        rd(10'h0a8);
        chk({r, got}, {2'h2, 32'h0000_0000});
        chk(cfg, expCfg());
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            capture <= $random(seed);
            capValid <= 1'b1;
            @(posedge core_clk);
            capValid <= 1'b0;
            wr(10'h0b0, 32'h00ff_ffff, 4'hf);
            chk(r, 2'h0);
            rd(10'h0b0);
            chk(got, {8'h00, capture});
            wrChk(0, {28'h000_0000, got[3:0]} | 32'h0000_0010, 4'h1);
        end
        summarize();
    end
endmodule // test_cacr_config_bank
